//--- hdl/ovx_pkg.sv
// Constants, register map, state and carrier types of the overexcitation stage.
// Assumes a 100 MHz aclk; the program cycle clock count is derived from it here.
`default_nettype none

package ovx_pkg;
  // Clock and program cycle, the program cycle doubles as the 5 ms time step.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROG_CYCLE_NS = 5_000_000;
  localparam int unsigned PROG_CYCLE_CLKS = PROG_CYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned REC_DEPTH = 12;

  // Ratio scales: 0.001 V/Hz units and 0.01 % units.
  localparam logic [31:0] MILLI_SCALE = 32'h0000_03e8;
  localparam logic [31:0] PCT_SCALE = 32'h0000_2710;
  localparam logic [31:0] PICK_ON_PCT = 32'h0000_2710;
  localparam logic [31:0] PICK_OFF_PCT = 32'h0000_25e4;

  // Register byte offsets.
  localparam logic [7:0] OFS_OPDLY = 8'h00;
  localparam logic [7:0] OFS_ALDLY = 8'h04;
  localparam logic [7:0] OFS_RELDLY = 8'h08;
  localparam logic [7:0] OFS_PICKUP = 8'h0c;
  localparam logic [7:0] OFS_FNOM = 8'h10;
  localparam logic [7:0] OFS_EVSEL = 8'h14;
  localparam logic [7:0] OFS_CNTCLR = 8'h18;
  localparam logic [7:0] OFS_COND = 8'h1c;
  localparam logic [7:0] OFS_EXPTIME = 8'h20;
  localparam logic [7:0] OFS_REMTIME = 8'h24;
  localparam logic [7:0] OFS_NOMVHZ = 8'h28;
  localparam logic [7:0] OFS_NOMRATIO = 8'h2c;
  localparam logic [7:0] OFS_PCTRATIO = 8'h30;
  localparam logic [7:0] OFS_CNT_START = 8'h34;
  localparam logic [7:0] OFS_CNT_TRIP = 8'h38;
  localparam logic [7:0] OFS_CNT_BLOCK = 8'h3c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFS_REC_SEL = 8'h48;
  localparam logic [7:0] OFS_REC_STAMP = 8'h4c;
  localparam logic [7:0] OFS_REC_DATA = 8'h50;
  localparam logic [7:0] OFS_REC_CODE = 8'h54;

  // Reset values; delays are in 5 ms steps.
  localparam logic [15:0] OPDLY_RST = 16'h0008;
  localparam logic [15:0] ALDLY_RST = 16'h0008;
  localparam logic [15:0] RELDLY_RST = 16'h0000;
  localparam logic [15:0] PICKUP_RST = 16'h0015;
  localparam logic [15:0] FNOM_RST = 16'h0032;
  localparam logic [7:0] EVSEL_RST = 8'hff;

  // Event kinds; ON events sit at bits 3:0, OFF events at bits 7:4.
  localparam int unsigned EV_START = 0;
  localparam int unsigned EV_ALARM = 1;
  localparam int unsigned EV_TRIP = 2;
  localparam int unsigned EV_BLOCK = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_START = 5'h02,
    ST_ALARM = 5'h04,
    ST_TRIP = 5'h08,
    ST_BLOCKED = 5'h10
  } ovx_state_e;

  typedef struct packed {
    logic valid;
    logic on;
    logic [1:0] kind;
    logic [31:0] stamp;
  } ovx_evt_s;

  typedef struct packed {
    logic [3:0] code;
    logic [15:0] remain;
    logic [15:0] meas;
    logic [31:0] stamp;
  } ovx_rec_s;
endpackage : ovx_pkg

`default_nettype wire

//--- hdl/ovx_divider.sv
// Sequential restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse given only while busy is low.
`default_nettype none

module ovx_divider #(
  parameter int unsigned W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quot
);
  logic [W:0] rem_q;
  logic [W:0] shifted;
  logic [W:0] diff;
  logic [$clog2(W+1)-1:0] cnt_q;

  // Trial subtraction of the divisor from the shifted remainder.
  always_comb
  begin
    shifted = {rem_q[W-1:0], quot[W-1]};
    diff = shifted - {1'b0, den};
  end

  // A zero divisor gives an all-ones quotient.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rem_q <= '0;
      quot <= '0;
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        rem_q <= '0;
        quot <= num;
        cnt_q <= ($clog2(W+1))'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        rem_q <= diff[W] ? shifted : diff;
        quot <= {quot[W-2:0], ~diff[W]};
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == 1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : ovx_divider

`default_nettype wire

//--- hdl/ovx_rec_mem.sv
// Small memory for the fault records, with registered read data.
// Assumes one writer and one reader on the same clock.
`default_nettype none

module ovx_rec_mem #(
  parameter int unsigned W = 68,
  parameter int unsigned DEPTH = 12,
  parameter int unsigned AW = 4
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem_q [DEPTH];

  // Write port, then read port; content is undefined until written.
  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule : ovx_rec_mem

`default_nettype wire

//--- hdl/ovx_event_block.sv
// Status, blocking, event and fault record logic of one overexcitation stage.
// Assumes an AXI4-Lite master, a same-clock measurement and curve element,
// and an asynchronous blocking pin from the blocking matrix.
//
// Summary of operation
// RULE_01 - Condition is normal, start, alarm, trip or blocked.
// RULE_02 - Expected operating time readable in 5 ms steps.
// RULE_03 - Signed remaining time to trip, 5 ms steps.
// RULE_04 - Nominal ratio is per-unit voltage over nominal frequency.
// RULE_05 - Measured ratio divided by nominal ratio readable.
// RULE_06 - Measured over pick-up ratio in 0.01 percent.
// RULE_07 - Blocking input sampled once per program cycle.
// RULE_08 - Blocking comes from the dedicated matrix input.
// RULE_09 - Unblocked pick-up raises start and starts timing.
// RULE_10 - Blocked pick-up raises blocked, no timing or trip.
// RULE_11 - Block during start clears start, runs release.
// RULE_12 - Blocking must arrive 5 ms before delay expires.
// RULE_13 - ON/OFF events, per-event selection for the buffer.
// RULE_14 - Each event carries a time stamp.
// RULE_15 - Clearable counters for start, trip and blocked.
// RULE_16 - Exactly one stage instance.
// RULE_17 - Twelve newest fault records, oldest overwritten.
// RULE_18 - Pick-up releases below 97 percent of setting.
`default_nettype none

module ovx_event_block #(
  parameter int unsigned TICK_CLKS = ovx_pkg::PROG_CYCLE_CLKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic block_in,
  input wire logic [15:0] vhz_meas,
  input wire logic [15:0] inv_extra,
  output logic start_o,
  output logic alarm_o,
  output logic trip_o,
  output logic blocked_o,
  output ovx_pkg::ovx_evt_s evt_o,
  output logic irq_o
);
  import ovx_pkg::*;

  localparam int unsigned RW = $bits(ovx_rec_s);
  localparam logic [3:0] REC_LAST = 4'(REC_DEPTH - 1);

  logic [31:0] tick_cnt_q, ts_q;
  logic tick, blk_meta_q, blk_sync_q, block_q;
  logic [15:0] opdly_q, aldly_q, reldly_q, pickup_q, fnom_q, nom_q, meas_q, inv_q;
  logic [7:0] evsel_q, mask_q, stat_q, pend_q, pend_low, ev_raw;
  logic [3:0] flags_w, flags_q, ev_on, ev_off, rec_sel_q, wptr_q, rec_n_q;
  logic [2:0] cnt_clr;
  logic [15:0] cnt_q [3];
  ovx_state_e state_q; // RULE_16
  logic [16:0] exp_w, elapsed_q, el_nx;
  logic [17:0] remain_w;
  logic [15:0] rel_q;
  logic [31:0] ratio_q, pct_q, div_num, div_den, div_quot;
  logic [1:0] op_q;
  logic go_q, div_done, pick_q, wr_fire, rd_fire, wr_ok;
  logic [2:0] low_idx;
  ovx_rec_s rec_w, rec_rd;

  function automatic logic [15:0] m16(input logic [15:0] o, input logic [31:0] d,
                                       input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : m16

  // Program cycle tick and time stamp counter in program cycles.
  assign tick = (tick_cnt_q == 32'(TICK_CLKS - 1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= '0;
      ts_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
      ts_q <= tick ? ts_q + 32'h1 : ts_q;
    end
  end

  // Blocking pin synchroniser, then one sample per program cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blk_meta_q <= 1'b0;
      blk_sync_q <= 1'b0;
      block_q <= 1'b0;
    end
    else
    begin
      blk_meta_q <= block_in; // RULE_08
      blk_sync_q <= blk_meta_q;
      if (tick)
      begin
        block_q <= blk_sync_q; // RULE_07
      end
    end
  end

  // Three divisions per program cycle: nominal, nominal ratio, pick-up ratio.
  always_comb
  begin
    case (op_q)
      2'h0:
      begin
        div_num = MILLI_SCALE; // RULE_04
        div_den = {16'h0, fnom_q};
      end
      2'h1:
      begin
        div_num = {16'h0, meas_q} * MILLI_SCALE; // RULE_05
        div_den = {16'h0, nom_q};
      end
      default:
      begin
        div_num = {16'h0, meas_q} * PCT_SCALE; // RULE_06
        div_den = {16'h0, pickup_q};
      end
    endcase
  end

  ovx_divider #(.W(32)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(go_q),
    .num(div_num),
    .den(div_den),
    .busy(),
    .done(div_done),
    .quot(div_quot)
  );

  // Division sequencing and pick-up decision with hysteresis.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_q <= 2'h0;
      go_q <= 1'b0;
      meas_q <= '0;
      inv_q <= '0;
      nom_q <= '0;
      ratio_q <= '0;
      pct_q <= '0;
      pick_q <= 1'b0;
    end
    else
    begin
      go_q <= tick | (div_done & (op_q != 2'h2));
      if (tick)
      begin
        op_q <= 2'h0;
        meas_q <= vhz_meas;
        inv_q <= inv_extra;
      end
      else if (div_done)
      begin
        op_q <= (op_q == 2'h2) ? op_q : op_q + 2'h1;
        case (op_q)
          2'h0: nom_q <= div_quot[15:0]; // RULE_04
          2'h1: ratio_q <= div_quot; // RULE_05
          default:
          begin
            pct_q <= div_quot; // RULE_06
            if (div_quot >= PICK_ON_PCT)
              pick_q <= 1'b1;
            else if (div_quot < PICK_OFF_PCT)
              pick_q <= 1'b0; // RULE_18
          end
        endcase
      end
    end
  end

  // Operating time: definite delay plus the inverse-curve share.
  assign exp_w = {1'b0, opdly_q} + {1'b0, inv_q}; // RULE_02
  assign el_nx = elapsed_q + 17'h1;
  assign remain_w = {1'b0, exp_w} - {1'b0, elapsed_q}; // RULE_03

  // Stage state machine, stepped once per program cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_NORMAL;
      elapsed_q <= '0;
      rel_q <= '0;
    end
    else if (tick)
    begin
      case (state_q)
        ST_NORMAL:
        begin
          if (pick_q && blk_sync_q)
            state_q <= ST_BLOCKED; // RULE_10
          else if (pick_q)
            state_q <= ST_START; // RULE_09
          else if (rel_q != 16'h0)
            rel_q <= rel_q - 16'h1;
          else
            elapsed_q <= '0;
        end
        ST_START, ST_ALARM, ST_TRIP:
        begin
          if (blk_sync_q || !pick_q)
          begin
            state_q <= ST_NORMAL; // RULE_11
            rel_q <= reldly_q;
            if (reldly_q == 16'h0)
              elapsed_q <= '0;
          end
          else
          begin
            elapsed_q <= el_nx;
            if (el_nx >= exp_w)
              state_q <= ST_TRIP;
            else if (el_nx >= {1'b0, aldly_q} && state_q == ST_START)
              state_q <= ST_ALARM;
          end
        end
        ST_BLOCKED:
        begin
          if (!pick_q)
            state_q <= ST_NORMAL;
          else if (!blk_sync_q)
            state_q <= ST_START;
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end

  // Output flags and their edges.
  always_comb
  begin
    flags_w[EV_START] = state_q inside {ST_START, ST_ALARM, ST_TRIP}; // RULE_01
    flags_w[EV_ALARM] = state_q inside {ST_ALARM, ST_TRIP};
    flags_w[EV_TRIP] = (state_q == ST_TRIP);
    flags_w[EV_BLOCK] = (state_q == ST_BLOCKED);
  end
  assign ev_on = flags_w & ~flags_q; // RULE_13
  assign ev_off = ~flags_w & flags_q;
  assign ev_raw = {ev_off, ev_on};
  assign {blocked_o, trip_o, alarm_o, start_o} = flags_q;

  // Lowest selected pending event goes out first.
  assign pend_low = pend_q & (~pend_q + 8'h01);
  always_comb
  begin
    low_idx = 3'h0;
    for (int i = 0; i < 8; i++)
      if (pend_low[i])
        low_idx = 3'(i);
  end

  // Event pending bits and the event output with its stamp.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q <= '0;
      pend_q <= '0;
      evt_o <= '0;
    end
    else
    begin
      flags_q <= flags_w;
      pend_q <= (pend_q & ~pend_low) | (ev_raw & evsel_q); // RULE_13
      evt_o.valid <= |pend_q;
      evt_o.on <= ~low_idx[2];
      evt_o.kind <= low_idx[1:0];
      if (|ev_raw)
        evt_o.stamp <= ts_q; // RULE_14
    end
  end

  // Sticky status, cleared by a read; a new event wins over the clear.
  assign rd_fire = arvalid & arready;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= '0;
    else
      stat_q <= ((rd_fire && araddr == OFS_IRQ_STAT) ? 8'h00 : stat_q) | ev_raw;
  end
  assign irq_o = |(stat_q & mask_q);

  // Cumulative counters; an event in the clear cycle counts as one.
  for (genvar g = 0; g < 3; g++)
  begin : g_cnt
    localparam int unsigned K = (g == 0) ? EV_START : (g == 1) ? EV_TRIP : EV_BLOCK;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        cnt_q[g] <= '0;
      else if (ev_on[K])
        cnt_q[g] <= cnt_clr[g] ? 16'h1 : cnt_q[g] + 16'h1; // RULE_15
      else if (cnt_clr[g])
        cnt_q[g] <= '0;
    end
  end

  // Fault record on start, trip or blocked ON edges.
  always_comb
  begin
    rec_w.stamp = ts_q; // RULE_14
    rec_w.meas = meas_q;
    rec_w.remain = remain_w[15:0];
    rec_w.code = ev_on[EV_TRIP] ? 4'(EV_TRIP) : ev_on[EV_BLOCK] ? 4'(EV_BLOCK)
                                                                 : 4'(EV_START);
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wptr_q <= '0;
      rec_n_q <= '0;
    end
    else if (ev_on[EV_START] | ev_on[EV_TRIP] | ev_on[EV_BLOCK])
    begin
      wptr_q <= (wptr_q == REC_LAST) ? 4'h0 : wptr_q + 4'h1; // RULE_17
      if (rec_n_q <= REC_LAST)
        rec_n_q <= rec_n_q + 4'h1;
    end
  end

  ovx_rec_mem #(.W(RW), .DEPTH(REC_DEPTH), .AW(4)) u_rec ( // RULE_17
    .aclk(aclk),
    .we(ev_on[EV_START] | ev_on[EV_TRIP] | ev_on[EV_BLOCK]),
    .waddr(wptr_q),
    .wdata(rec_w),
    .raddr(rec_sel_q),
    .rdata(rec_rd)
  );

  // Write channel: address and data are taken together.
  assign awready = awvalid & wvalid & ~bvalid;
  assign wready = awready;
  assign wr_fire = awready;
  assign wr_ok = awaddr inside {OFS_OPDLY, OFS_ALDLY, OFS_RELDLY, OFS_PICKUP, OFS_FNOM,
                                OFS_EVSEL, OFS_CNTCLR, OFS_IRQ_MASK, OFS_REC_SEL};
  assign cnt_clr = (wr_fire && awaddr == OFS_CNTCLR && wstrb[0]) ? wdata[2:0] : 3'h0;

  // Settings written by software.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opdly_q <= OPDLY_RST;
      aldly_q <= ALDLY_RST;
      reldly_q <= RELDLY_RST;
      pickup_q <= PICKUP_RST;
      fnom_q <= FNOM_RST;
      evsel_q <= EVSEL_RST;
      mask_q <= '0;
      rec_sel_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        case (awaddr)
          OFS_OPDLY: opdly_q <= m16(opdly_q, wdata, wstrb);
          OFS_ALDLY: aldly_q <= m16(aldly_q, wdata, wstrb);
          OFS_RELDLY: reldly_q <= m16(reldly_q, wdata, wstrb);
          OFS_PICKUP: pickup_q <= m16(pickup_q, wdata, wstrb);
          OFS_FNOM: fnom_q <= m16(fnom_q, wdata, wstrb);
          OFS_EVSEL: evsel_q <= wstrb[0] ? wdata[7:0] : evsel_q;
          OFS_IRQ_MASK: mask_q <= wstrb[0] ? wdata[7:0] : mask_q;
          OFS_REC_SEL: rec_sel_q <= wstrb[0] ? wdata[3:0] : rec_sel_q;
          default: ;
        endcase
      end
    end
  end

  // Read channel: one word per request, answered one cycle later.
  assign arready = ~rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (araddr)
        OFS_OPDLY: rdata <= {16'h0, opdly_q};
        OFS_ALDLY: rdata <= {16'h0, aldly_q};
        OFS_RELDLY: rdata <= {16'h0, reldly_q};
        OFS_PICKUP: rdata <= {16'h0, pickup_q};
        OFS_FNOM: rdata <= {16'h0, fnom_q};
        OFS_EVSEL: rdata <= {24'h0, evsel_q};
        OFS_CNTCLR: rdata <= '0;
        OFS_COND: rdata <= {24'h0, block_q, 2'h0, state_q}; // RULE_01
        OFS_EXPTIME: rdata <= {15'h0, exp_w}; // RULE_02
        OFS_REMTIME: rdata <= {{14{remain_w[17]}}, remain_w}; // RULE_03
        OFS_NOMVHZ: rdata <= {16'h0, nom_q};
        OFS_NOMRATIO: rdata <= ratio_q;
        OFS_PCTRATIO: rdata <= pct_q;
        OFS_CNT_START: rdata <= {16'h0, cnt_q[0]};
        OFS_CNT_TRIP: rdata <= {16'h0, cnt_q[1]};
        OFS_CNT_BLOCK: rdata <= {16'h0, cnt_q[2]};
        OFS_IRQ_STAT: rdata <= {24'h0, stat_q};
        OFS_IRQ_MASK: rdata <= {24'h0, mask_q};
        OFS_REC_SEL: rdata <= {20'h0, rec_n_q, 4'h0, rec_sel_q};
        OFS_REC_STAMP: rdata <= rec_rd.stamp;
        OFS_REC_DATA: rdata <= {rec_rd.remain, rec_rd.meas};
        OFS_REC_CODE: rdata <= {28'h0, rec_rd.code};
        default:
        begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Checks of the stage behaviour.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_ONE_CONDITION: assert property ($onehot(state_q)) // RULE_01
    else $error("Stage condition is not one-hot.");
  AST_BLOCK_HELD: assert property (!tick |=> $stable(block_q)) // RULE_07
    else $error("Blocking sample changed outside a program cycle start.");
  AST_START_ON_PICK: assert property ( // RULE_09
    tick && state_q == ST_NORMAL && pick_q && !blk_sync_q |=> ##1 start_o)
    else $error("Unblocked pick-up did not raise start.");
  AST_BLOCKED_NO_TIME: assert property ( // RULE_10
    state_q == ST_BLOCKED |=> $stable(elapsed_q) && !trip_o)
    else $error("Timing ran while blocked.");
  AST_BLOCK_DROPS_START: assert property ( // RULE_11
    tick && start_o && blk_sync_q && state_q != ST_NORMAL |=> ##1 !start_o)
    else $error("Blocking did not clear start.");
  AST_TRIP_AT_TIME: assert property ( // RULE_03
    $rose(trip_o) |-> $past(elapsed_q) >= $past(exp_w, 2))
    else $error("Trip before the operating time.");
  AST_HYSTERESIS: assert property ( // RULE_18
    div_done && op_q == 2'h2 && pick_q && div_quot >= PICK_OFF_PCT |=> pick_q)
    else $error("Pick-up released above the reset ratio.");
  AST_EVT_SELECTED: assert property ( // RULE_13
    evt_o.valid |-> ($past(evsel_q) & (8'h01 << {~evt_o.on, evt_o.kind})) != 8'h00)
    else $error("Unselected event reached the buffer.");
  AST_CNT_START: assert property ( // RULE_15
    ev_on[EV_START] && !cnt_clr[0] |=> cnt_q[0] == $past(cnt_q[0]) + 16'h1)
    else $error("Start counter missed an event.");
  AST_REC_WRAP: assert property ( // RULE_17
    u_rec.we && wptr_q == REC_LAST |=> wptr_q == 4'h0 && rec_n_q == 4'hc)
    else $error("Fault record pointer did not wrap at twelve.");

  COV_TRIP: cover property ($rose(trip_o));
  COV_BLOCKED: cover property ($rose(blocked_o));
  COV_REC_WRAP: cover property (u_rec.we && wptr_q == REC_LAST);
  COV_IRQ: cover property ($rose(irq_o));
endmodule : ovx_event_block

`default_nettype wire

//--- testbench/ovx_far_model.sv
// Far side of the stage: measurement feed and blocking matrix output.
// Assumes the bench sets the commanded levels just after aclk rises.
`default_nettype none

module ovx_far_model (
  input wire logic blk_cmd,
  input wire logic [15:0] meas_cmd,
  input wire logic [15:0] extra_cmd,
  output logic block_in,
  output logic [15:0] vhz_meas,
  output logic [15:0] inv_extra
);
  timeunit 1ns;
  timeprecision 1ns;
  // The matrix raises blocking on its own line, only when told, at whatever time the bench commands it.
  assign block_in = blk_cmd;
  // Measured ratio and inverse-curve time follow the commanded fault level.
  assign vhz_meas = meas_cmd;
  assign inv_extra = extra_cmd;
endmodule : ovx_far_model

`default_nettype wire

//--- testbench/ovx_event_block_tb.sv
// Bench of the overexcitation stage: AXI4-Lite tasks and stage sequences.
// Assumes a short program cycle and the far-side model beside the design.
`default_nettype none

module ovx_event_block_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ovx_pkg::*;
  localparam int unsigned TICK = 200;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, blk_cmd, block_in;
  logic awready, wready, bvalid, arready, rvalid, start_o, alarm_o, trip_o, blocked_o, irq_o;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, last_stamp;
  logic [3:0] wstrb, on_seen;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] meas_cmd, extra_cmd, vhz_meas, inv_extra;
  ovx_evt_s evt_o;
  int err_total, total_checks, ev_n, n0;

  ovx_event_block #(.TICK_CLKS(TICK)) ovx_event_block_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .block_in(block_in),
    .vhz_meas(vhz_meas), .inv_extra(inv_extra), .start_o(start_o), .alarm_o(alarm_o),
    .trip_o(trip_o), .blocked_o(blocked_o), .evt_o(evt_o), .irq_o(irq_o));
  ovx_far_model ovx_far_model_i (.blk_cmd(blk_cmd), .meas_cmd(meas_cmd),
    .extra_cmd(extra_cmd), .block_in(block_in), .vhz_meas(vhz_meas), .inv_extra(inv_extra));

  // Free-running 100 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // A wait that used its whole bound is a hang and ends the run.
  task automatic wt(input int n);
    if (n >= 1000)
    begin
      err_total++;
      print_verdict();
    end
  endtask : wt

  // One AXI4-Lite write; address and data go out together.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 && ++n < 1000);
    wt(n);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    n = 0;
    do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 1000);
    wt(n);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // One AXI4-Lite read; data and response are taken at the rvalid edge.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1 && ++n < 1000);
    wt(n);
    arvalid <= 1'b0;
    n = 0;
    do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 1000);
    wt(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Reads a register and compares it.
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rv, rs);
    chk(nm, rv, e);
  endtask : rc

  // Polls the condition register until the stage reaches the given state.
  task automatic wait_cond(input logic [4:0] st);
    int n;
    do axi_rd(OFS_COND, rv, rs); while (rv[4:0] !== st && ++n < 1000);
    wt(n);
  endtask : wait_cond

  // Watches the event port: kinds seen as ON, count, and stamp order.
  always @(posedge aclk)
    if (evt_o.valid === 1'b1)
    begin
      ev_n <= ev_n + 1;
      on_seen[evt_o.kind] <= on_seen[evt_o.kind] | evt_o.on;
      chk("stamp order", 32'(evt_o.stamp >= last_stamp), 32'h1);
      last_stamp <= evt_o.stamp;
    end

  // Main sequence: reset values, fault to trip, blocking, masked events, hysteresis.
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, blk_cmd, aresetn} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'hf;
    {meas_cmd, extra_cmd, on_seen, last_stamp} = 68'h2_0000_0000_0;
    extra_cmd = 16'h0002;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc("opdly", OFS_OPDLY, 32'h8);
    rc("aldly", OFS_ALDLY, 32'h8);
    rc("reldly", OFS_RELDLY, 32'h0);
    rc("pickup", OFS_PICKUP, 32'h15);
    rc("fnom", OFS_FNOM, 32'h32);
    rc("evsel", OFS_EVSEL, 32'hff);
    rc("mask", OFS_IRQ_MASK, 32'h0);
    // The nominal ratio exists only after the first program cycle has run its division.
    repeat (2 * TICK) @(posedge aclk);
    rc("nomvhz", OFS_NOMVHZ, 32'h14);
    rc("cond", OFS_COND, 32'h1);
    axi_rd(8'hfc, rv, rs);
    chk("unmapped", 32'(rs), 32'(RESP_SLVERR));
    axi_wr(OFS_COND, 32'h0, rs);
    chk("ro write", 32'(rs), 32'(RESP_SLVERR));
    axi_wr(OFS_OPDLY, 32'h3, rs);
    axi_wr(OFS_ALDLY, 32'h1, rs);
    axi_wr(OFS_IRQ_MASK, 32'h4, rs);
    meas_cmd <= 16'd21;
    wait_cond(ST_START);
    chk("start", 32'(start_o), 32'h1);
    rc("pct", OFS_PCTRATIO, 32'h2710);
    rc("nomratio", OFS_NOMRATIO, 32'd1050);
    rc("exptime", OFS_EXPTIME, 32'h5);
    rc("remtime", OFS_REMTIME, 32'h5);
    chk("irq masked", 32'(irq_o), 32'h0);
    wait_cond(ST_TRIP);
    chk("trip", 32'(trip_o), 32'h1);
    chk("alarm", 32'(alarm_o), 32'h1);
    chk("irq on", 32'(irq_o), 32'h1);
    rc("irq stat", OFS_IRQ_STAT, 32'h7);
    chk("irq off", 32'(irq_o), 32'h0);
    rc("cnt start", OFS_CNT_START, 32'h1);
    rc("cnt trip", OFS_CNT_TRIP, 32'h1);
    axi_wr(OFS_CNTCLR, 32'h7, rs);
    rc("cnt clr", OFS_CNT_TRIP, 32'h0);
    blk_cmd <= 1'b1;
    wait_cond(ST_BLOCKED);
    chk("flags", 32'({start_o, trip_o, blocked_o}), 32'h1);
    repeat (10 * TICK) @(posedge aclk);
    rc("held", OFS_COND, 32'h90);
    rc("cnt trip", OFS_CNT_TRIP, 32'h0);
    rc("cnt block", OFS_CNT_BLOCK, 32'h1);
    axi_rd(OFS_REC_SEL, rv, rs);
    chk("records", 32'(rv[11:8]), 32'h3);
    axi_wr(OFS_REC_SEL, 32'h1, rs);
    rc("rec code", OFS_REC_CODE, 32'h2);
    rc("rec data", OFS_REC_DATA, 32'h15);
    chk("on events", 32'(on_seen), 32'hf);
    // Toggle blocking until the record memory has wrapped.
    repeat (5)
    begin
      blk_cmd <= 1'b0;
      wait_cond(ST_START);
      blk_cmd <= 1'b1;
      wait_cond(ST_BLOCKED);
    end
    axi_rd(OFS_REC_SEL, rv, rs);
    chk("records full", 32'(rv[11:8]), 32'hc);
    axi_wr(OFS_EVSEL, 32'h0, rs);
    n0 = ev_n;
    blk_cmd <= 1'b0;
    meas_cmd <= 16'd0;
    wait_cond(ST_NORMAL);
    repeat (4) @(posedge aclk);
    chk("unselected", 32'(ev_n), 32'(n0));
    axi_wr(OFS_PICKUP, 32'd100, rs);
    axi_wr(OFS_OPDLY, 32'hff, rs);
    axi_wr(OFS_ALDLY, 32'hff, rs);
    meas_cmd <= 16'd100;
    wait_cond(ST_START);
    meas_cmd <= 16'd98;
    repeat (4 * TICK) @(posedge aclk);
    rc("hold", OFS_COND, 32'h2);
    meas_cmd <= 16'd96;
    repeat (4 * TICK) @(posedge aclk);
    rc("release", OFS_COND, 32'h1);
    print_verdict();
  end
endmodule : ovx_event_block_tb

`default_nettype wire
